// ==== design/srs_pkg.sv ====
// Constants and carrier types for the readback select register bank.
// Assumes an on-chip register access port driven by the serial frame decoder.
package srs_pkg;

    // Register offsets
    localparam logic [7:0]  SRS_ADDR_RB_CTRL    = 8'h64;
    localparam logic [7:0]  SRS_ADDR_BURST_MASK = 8'h65;

    // Readback control and burst mask fields
    localparam int          SRS_AUTO_RD_BIT     = 9;
    localparam int          SRS_TOP_SEL_BIT     = 8;
    localparam int          SRS_RB_ADDR_MSB     = 7;
    localparam int          SRS_MASK_MSB        = 9;
    localparam int          SRS_MASK_BITS       = 10;

    // Reset values
    localparam logic [15:0] SRS_RB_CTRL_RST     = 16'h0000;
    localparam logic [15:0] SRS_BURST_MASK_RST  = 16'h03FF;

    // Addresses of the registers that own a burst mask bit, by mask bit index
    localparam logic [7:0]  SRS_GATED_ADDR [SRS_MASK_BITS] = '{
        8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48
    };
    // Comparator output register: no mask bit, never skipped
    localparam logic [7:0]  SRS_ADDR_DIN_COMP   = 8'h3E;

    // Longest run of addresses the burst walker looks past
    localparam int          SRS_SKIP_SPAN       = SRS_MASK_BITS + 1;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } srs_reg_req_s;

    typedef struct packed {
        logic        start;
        logic        step;
        logic [7:0]  start_addr;
    } srs_burst_req_s;

    typedef struct packed {
        logic        conv_ready;
        logic        alert;
        logic [3:0]  din_comp;
    } srs_flags_s;

endpackage

// ==== design/srs_readback_select.sv ====
// Readback select and burst skip mask registers with frame header and burst walker.
// Assumes a frame decoder on ref_clk issuing single-cycle register and burst requests;
// comparator outputs arrive asynchronously.
`timescale 1ns/1ns

// Behaviour
// - The readback control register picks the register whose contents go into the next read frame.
// - With auto read enabled on bit 9, every access returns data from the readback address.
// - With bit 8 clear, frame bits 30 to 24 carry readback address bits 6 to 0.
// - With bit 8 set, frame bit 30 is zero and bits 29 to 24 carry conversion ready, alert and four comparator outputs.
// - The readback address field in bits 7 to 0 is read/write and resets to zero.
// - A burst read skips each selectable register whose mask bit is 0; the mask resets to 0x3FF.
// - Mask bits 0 to 9 gate alert status, reg_a, results 1-2, diagnostics 0-3, counter, supply status.
// - Registers without a mask bit are always returned when the burst range covers them.
// - The start address of a burst is always returned, whatever its mask bit.
// - A burst may begin at the comparator output register, which has no mask bit and is never skipped.
module srs_readback_select
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    // Register access
    input  wire srs_pkg::srs_reg_req_s  reg_req,
    output logic [15:0]                 reg_rdata,
    output logic                        reg_rd_hit,
    // Live flags
    input  wire srs_pkg::srs_flags_s    flags,
    // Read frame header
    output logic [6:0]                  frame_top_bits,
    output logic                        auto_read_en,
    output logic [7:0]                  readback_addr,
    // Burst walker
    input  wire srs_pkg::srs_burst_req_s burst_req,
    output logic [7:0]                  burst_addr,
    output logic                        burst_active
);
    import srs_pkg::*;

    typedef struct packed {
        logic                     auto_rd;
        logic                     top_sel;
        logic [7:0]               rb_addr;
        logic [SRS_MASK_MSB:0]    mask;
        logic [3:0]               din_s1;
        logic [3:0]               din_s2;
        logic [3:0]               din_s3;
        logic [3:0]               din_stable;
        logic [6:0]               frame_top;
        logic [15:0]              rdata;
        logic                     rd_hit;
        logic [7:0]               b_addr;
        logic                     b_active;
    } srs_state_s;

    srs_state_s st_q;
    srs_state_s st_d;

    // True when the address owns a mask bit that is cleared
    function automatic logic is_skipped(input logic [7:0] a,
                                        input logic [SRS_MASK_MSB:0] m);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < SRS_MASK_BITS; i++)
        begin
            if (a == SRS_GATED_ADDR[i] && !m[i])
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // First address after a that the burst returns
    function automatic logic [7:0] next_returned(input logic [7:0] a,
                                                 input logic [SRS_MASK_MSB:0] m);
        logic [7:0] cand;
        logic [7:0] res;
        logic       found;
        res   = a + 8'h01;
        found = 1'b0;
        for (int i = 1; i <= SRS_SKIP_SPAN; i++)
        begin
            cand = a + 8'(i);
            if (!found && !is_skipped(cand, m))
            begin
                res   = cand;
                found = 1'b1;
            end
        end
        return res;
    endfunction

    always_comb
    begin
        st_d = st_q;

        // Register writes; upper bits are dropped
        if (reg_req.wr)
        begin
            if (reg_req.addr == SRS_ADDR_RB_CTRL)
            begin
                st_d.auto_rd = reg_req.wdata[SRS_AUTO_RD_BIT];
                st_d.top_sel = reg_req.wdata[SRS_TOP_SEL_BIT];
                st_d.rb_addr = reg_req.wdata[SRS_RB_ADDR_MSB:0];
            end
            else if (reg_req.addr == SRS_ADDR_BURST_MASK)
            begin
                st_d.mask = reg_req.wdata[SRS_MASK_MSB:0];
            end
        end

        // Register reads; reserved bits return zero
        st_d.rd_hit = 1'b0;
        st_d.rdata  = 16'h0000;
        if (reg_req.rd)
        begin
            if (reg_req.addr == SRS_ADDR_RB_CTRL)
            begin
                st_d.rd_hit = 1'b1;
                st_d.rdata  = {6'h00, st_q.auto_rd, st_q.top_sel, st_q.rb_addr};
            end
            else if (reg_req.addr == SRS_ADDR_BURST_MASK)
            begin
                st_d.rd_hit = 1'b1;
                st_d.rdata  = {6'h00, st_q.mask};
            end
        end

        // Comparator synchroniser; a level is taken once stages two and three agree
        st_d.din_s1 = flags.din_comp;
        st_d.din_s2 = st_q.din_s1;
        st_d.din_s3 = st_q.din_s2;
        for (int i = 0; i < 4; i++)
        begin
            if (st_q.din_s2[i] == st_q.din_s3[i])
            begin
                st_d.din_stable[i] = st_q.din_s3[i];
            end
        end

        // Header bits placed in the upper part of later read frames
        if (st_q.top_sel)
        begin
            st_d.frame_top = {1'b0, flags.conv_ready, flags.alert, st_q.din_stable};
        end
        else
        begin
            st_d.frame_top = st_q.rb_addr[6:0];
        end

        // Burst walker: start is always returned, later steps skip masked registers
        if (burst_req.start)
        begin
            st_d.b_addr   = burst_req.start_addr;
            st_d.b_active = 1'b1;
        end
        else if (burst_req.step && st_q.b_active)
        begin
            st_d.b_addr = next_returned(st_q.b_addr, st_q.mask);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q            <= '0;
            st_q.auto_rd    <= SRS_RB_CTRL_RST[SRS_AUTO_RD_BIT];
            st_q.top_sel    <= SRS_RB_CTRL_RST[SRS_TOP_SEL_BIT];
            st_q.rb_addr    <= SRS_RB_CTRL_RST[SRS_RB_ADDR_MSB:0];
            st_q.mask       <= SRS_BURST_MASK_RST[SRS_MASK_MSB:0];
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata      = st_q.rdata;
    assign reg_rd_hit     = st_q.rd_hit;
    assign frame_top_bits = st_q.frame_top;
    assign auto_read_en   = st_q.auto_rd;
    assign readback_addr  = st_q.rb_addr;
    assign burst_addr     = st_q.b_addr;
    assign burst_active   = st_q.b_active;

endmodule // srs_readback_select

// ==== tb/srs_readback_select_checker.sv ====
// Port assertions for the readback select bank.
// Assumes it is bound onto srs_readback_select.
`timescale 1ns/1ns
module srs_checker
(
    // Clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rstn,
    // Watched ports
    input wire srs_pkg::srs_reg_req_s   reg_req,
    input wire logic [15:0]             reg_rdata,
    input wire logic                    reg_rd_hit,
    input wire srs_pkg::srs_flags_s     flags,
    input wire logic [6:0]              frame_top_bits,
    input wire logic                    auto_read_en,
    input wire logic [7:0]              readback_addr,
    input wire srs_pkg::srs_burst_req_s burst_req,
    input wire logic [7:0]              burst_addr,
    input wire logic                    burst_active
);
    import srs_pkg::*;
    logic [9:0] mask_q;
    logic       sel_q;
    logic       stp;
    function automatic logic gt(logic [7:0] x, logic [9:0] m);
        return x >= 8'h3F && x <= 8'h48 && !m[4'(x - 8'h3F)];
    endfunction
    assign stp = burst_req.step && !burst_req.start && burst_active;
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn)
            {mask_q, sel_q} <= {10'h3FF, 1'b0};
        else if (reg_req.wr && reg_req.addr == 8'h65)
            mask_q <= reg_req.wdata[9:0];
        else if (reg_req.wr && reg_req.addr == 8'h64)
            sel_q <= reg_req.wdata[8];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_mask_read: assert property (reg_req.rd && reg_req.addr == 8'h65
        |=> reg_rd_hit && reg_rdata == {6'h00, $past(mask_q)}) else $error("mask read");
    a_miss_read: assert property (reg_req.rd && reg_req.addr[7:1] != 7'h32
        |=> !reg_rd_hit && reg_rdata == 16'h0000) else $error("unmapped read");
    a_ctrl_write: assert property (reg_req.wr && reg_req.addr == 8'h64
        |=> {auto_read_en, 1'b0, readback_addr} == ($past(reg_req.wdata[9:0]) & 10'h2FF))
        else $error("ctrl");
    a_top_addr: assert property (!sel_q
        |=> frame_top_bits == $past(readback_addr[6:0])) else $error("top addr");
    a_top_flags: assert property (sel_q
        |=> frame_top_bits[6:4] == {1'b0, $past(flags.conv_ready), $past(flags.alert)}) else $error("top flags");
    a_start_addr: assert property (burst_req.start
        |=> burst_active && burst_addr == $past(burst_req.start_addr)) else $error("start");
    a_step_next: assert property (stp && !gt(burst_addr + 8'h01, mask_q)
        |=> burst_addr == $past(burst_addr) + 8'h01) else $error("step next");
    a_step_skip: assert property (stp
        |=> !gt(burst_addr, $past(mask_q))) else $error("step skip");
endmodule // srs_checker
bind srs_readback_select srs_checker chk_i (.*);

// ==== tb/srs_host_model.sv ====
// Host controller issuing register and burst requests.
// Assumes one request at a time on ref_clk.
`timescale 1ns/1ns
module srs_host_model
(
    // Clock and answers
    input  wire logic               ref_clk,
    input  wire logic [15:0]        reg_rdata,
    input  wire logic [7:0]         burst_addr,
    // Requests
    output srs_pkg::srs_reg_req_s   reg_req = '0,
    output srs_pkg::srs_burst_req_s burst_req = '0
);
    task wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge ref_clk);
        reg_req <= '{1'b1, 1'b0, a, w};
        @(posedge ref_clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~w};
    endtask
    task rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge ref_clk);
        reg_req <= '{1'b0, 1'b1, a, 16'h5A5A};
        @(posedge ref_clk);
        reg_req <= '{1'b0, 1'b0, ~a, 16'hA5A5};
        #1 q = reg_rdata;
    endtask
    task bst(input logic s, input logic [7:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        burst_req <= '{s, !s, a};
        @(posedge ref_clk);
        burst_req <= '{1'b0, 1'b0, ~a};
        #1 q = burst_addr;
    endtask
endmodule // srs_host_model

// ==== tb/tb_spi_readback_select.sv ====
// Self-checking bench for the readback select bank.
// Assumes srs_pkg, the design and the host model are compiled first.
`timescale 1ns/1ns
module tb_spi_readback_select;
    import srs_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0, reg_rd_hit, auto_read_en, burst_active;
    srs_reg_req_s   reg_req;
    srs_burst_req_s burst_req;
    srs_flags_s     flags = '0;
    logic [15:0]    reg_rdata, d;
    logic [7:0]     readback_addr, burst_addr, b;
    logic [6:0]     frame_top_bits;
    int             err_count = 0, checked = 0, ctrl = 0, mask = 'h3FF, a, e, n;
    int unsigned    rs = 23;
    srs_readback_select DUT (.*);
    srs_host_model host (.ref_clk, .reg_rdata, .burst_addr, .reg_req, .burst_req);
    function automatic int unsigned rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic bit gt(int x);
        return x >= 'h3F && x <= 'h48 && !mask[x - 'h3F];
    endfunction
    task automatic chk(string s, int x, logic [15:0] g);
        checked++;
        if (g !== 16'(x))
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", s, 16'(x), g);
        end
    endtask
    task results();
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #2 ref_clk = ~ref_clk;
    initial
    begin
        #40000 err_count++;
        results();
    end
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            a = 'h64 + rnd() % 3;
            e = rnd() & 'hFFFF;
            @(posedge ref_clk) flags <= srs_flags_s'(rnd());
            if (i > 0) host.wr(8'(a), 16'(e));
            if (i > 0 && a == 'h64) ctrl = e & 'h3FF;
            if (i > 0 && a == 'h65) mask = e & 'h3FF;
            host.rd(8'(a), d);
            chk("rdata", a == 'h64 ? ctrl : a == 'h65 ? mask : 0, d);
            #16;
            chk("ctl", ctrl & 'h2FF, {6'h00, auto_read_en, 1'b0, readback_addr});
            chk("top", ctrl[8] ? int'(flags) : ctrl & 'h7F, 16'(frame_top_bits));
        end
        for (int i = 0; i < 8; i++)
        begin
            e = i == 1 ? 0 : rnd() & 'hFFFF;
            host.wr(8'h65, 16'(e));
            mask = e & 'h3FF;
            n = i == 0 ? 'h3E : i == 1 ? 'h41 : 'h3C + rnd() % 14;
            host.bst(1'b1, 8'(n), b);
            chk("start", n, 16'(b));
            chk("active", 1, 16'(burst_active));
            repeat (12)
            begin
                n = (n + 1) % 256;
                while (gt(n)) n = (n + 1) % 256;
                host.bst(1'b0, 8'h00, b);
                chk("step", n, 16'(b));
            end
        end
        results();
    end
endmodule // tb_spi_readback_select
